// ### rtl/pvf_ctrl.sv
// Vertical format unit, interrupt request and operator panel controller
`timescale 1ns/1ps
`include "pvf_params.svh"
// Overview of operation
// - Start code clears and loads format buffer
// - Stop code ends loading, printing resumes
// - Buffer holds one channel per line, 132
// - Tab code makes next line feed seek channel
// - Line one always holds top-of-form channel
// - Interrupt only while enable bit set
// - Ready or error raises request when enabled
// - Level 4, vector 200, both parameters
// - Ready when a character can be taken
// - Error bit follows any error condition
// - Fault light for any mechanism fault
// - Light self-clears, except after paper reload
// - No on-line while fault light lit
// - Spacing toggle off-line; program code selects 8 lpi for one move
// - Top-of-form button off-line, to form top
// - Paper advance button slews while held
module pvf_ctrl import pvf_pkg::*; #(
  parameter int STEP_CYC = `PVF_STEP_CYC,
  parameter int FORM_DEFAULT = `PVF_FORM_DEFAULT,
  parameter logic [2:0] IRQ_LEVEL = `PVF_IRQ_LEVEL,
  parameter logic [8:0] IRQ_VECTOR = `PVF_IRQ_VECTOR
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic char_wr,
  input wire logic [7:0] char_data,
  input wire logic int_enable,
  input wire logic [6:0] fault_pins,
  input wire logic fault_button,
  input wire logic online_button,
  input wire logic lpi_button,
  input wire logic tof_button,
  input wire logic advance_button,
  input wire logic mech_take,
  output logic ready,
  output logic error,
  output logic irq_req,
  output logic [2:0] irq_level,
  output logic [8:0] irq_vector,
  output logic print_valid,
  output logic [7:0] print_data,
  output logic paper_step,
  output logic step_eighth,
  output logic fault_lit,
  output logic online_lit,
  output logic lpi8_lit,
  output logic vfu_loaded,
  output logic [7:0] form_line
);
  pvf_st_t s;
  pvf_st_t n;
  logic [`PVF_PIN_W-1:0] sy;
  logic [`PVF_PIN_W-1:0] rise;
  logic [`PVF_PIN_W-1:0] fall;

  // Panel and mechanism pins are asynchronous
  pvf_sync #(.W(`PVF_PIN_W)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({mech_take, advance_button, tof_button, lpi_button, online_button, fault_button, fault_pins}),
    .q(sy)
  );

  assign rise = sy & ~s.prev;
  assign fall = ~sy & s.prev;

  // Active form length: loaded format, else the default form
  function automatic logic [7:0] form_len(input logic loaded, input logic [7:0] len);
    form_len = loaded ? len : 8'(FORM_DEFAULT);
  endfunction

  // Next form line, wrapping at the form end
  function automatic logic [7:0] next_line(input logic [7:0] line, input logic [7:0] flen);
    next_line = (line + 8'h01 >= flen) ? 8'h00 : line + 8'h01;
  endfunction

  // Channel number of a tab code, or none
  function automatic logic [3:0] chan_of(input logic [7:0] code);
    if (code >= `PVF_TAB_FIRST && code <= `PVF_TAB_LAST) begin
      chan_of = code[3:0];
    end else begin
      chan_of = `PVF_CH_NONE;
    end
  endfunction

  // Launch a paper motion; spacing is latched for the whole move
  function automatic pvf_st_t start_move(input pvf_st_t c, input pvf_move_t k, input logic [3:0] tgt);
    pvf_st_t r;
    r = c;
    r.st = PVF_MOVE;
    r.kind = k;
    r.target = tgt;
    r.timer = 16'(STEP_CYC - 1);
    r.move_left = form_len(c.vfu_loaded, c.vfu_len);
    r.eighth = c.lpi8_panel | c.prog_8lpi;
    r.prog_8lpi = 1'b0;
    r.tab_pend = 1'b0;
    start_move = r;
  endfunction

  // Next-state logic for the whole controller
  always_comb begin
    logic fault_now;
    logic accept;
    logic [7:0] nl;
    fault_now = 1'b0;
    accept = 1'b0;
    nl = 8'h00;
    n = s;
    n.step = 1'b0;
    n.prev = sy;

    // Reload latch: set on paper reload, cleared by the button; set wins
    if (fall[`PVF_PIN_PAPER_OUT]) begin
      n.reload_hold = 1'b1;
    end else if (rise[`PVF_PIN_FAULT_BTN]) begin
      n.reload_hold = 1'b0;
    end
    fault_now = (|sy[6:0]) | n.reload_hold;
    n.fault = fault_now;

    // Fault drops the link; button toggles but cannot enter on-line
    if (fault_now) begin
      n.online = 1'b0;
    end else if (rise[`PVF_PIN_ONLINE_BTN]) begin
      n.online = ~s.online;
    end

    // Spacing toggle is live only off-line
    if (rise[`PVF_PIN_LPI_BTN] && !s.online) begin
      n.lpi8_panel = ~s.lpi8_panel;
    end

    unique case (s.st)
      PVF_IDLE: begin
        if (char_wr && s.ready) begin
          accept = 1'b1;
          if (s.loading) begin
            if (char_data == `PVF_CODE_STOP) begin
              n.loading = 1'b0;
              n.vfu_loaded = (s.vfu_len != 8'h00);
            end else if (s.vfu_len < `PVF_FORM_MAX_W) begin
              // Line one is forced to top-of-form
              n.vfu[s.vfu_len] = (s.vfu_len == 8'h00) ? `PVF_CH_TOF : chan_of(char_data);
              n.vfu_len = s.vfu_len + 8'h01;
            end
          end else if (char_data == `PVF_CODE_START) begin
            n.loading = 1'b1;
            n.vfu_loaded = 1'b0;
            n.vfu_len = 8'h00;
            n.vfu = {`PVF_FORM_MAX{`PVF_CH_NONE}};
          end else if (chan_of(char_data) != `PVF_CH_NONE) begin
            n.tab_pend = 1'b1;
            n.tab_ch = chan_of(char_data);
          end else if (char_data == `PVF_CODE_SHIFT8) begin
            n.prog_8lpi = 1'b1;
          end else begin
            n.print_data = char_data;
            n.print_valid = 1'b1;
            n.st = PVF_PRINT;
          end
        end else if (rise[`PVF_PIN_TOF_BTN] && !s.online) begin
          n = start_move(n, PVF_MV_TOP, `PVF_CH_TOF);
        end else if (sy[`PVF_PIN_ADV_BTN]) begin
          n = start_move(n, PVF_MV_SLEW, `PVF_CH_NONE);
        end
      end
      PVF_PRINT: begin
        // Character stays offered until the mechanism takes it
        if (rise[`PVF_PIN_TAKE]) begin
          n.print_valid = 1'b0;
          if (s.print_data == `PVF_CODE_LF) begin
            n = start_move(n, s.tab_pend ? PVF_MV_TAB : PVF_MV_ONE, s.tab_ch);
          end else if (s.print_data == `PVF_CODE_FF) begin
            n = start_move(n, PVF_MV_TOP, `PVF_CH_TOF);
          end else begin
            n.st = PVF_IDLE;
          end
        end
      end
      PVF_MOVE: begin
        if (s.timer != 16'h0000) begin
          n.timer = s.timer - 16'h0001;
        end else if (s.kind == PVF_MV_SLEW && !sy[`PVF_PIN_ADV_BTN]) begin
          n.st = PVF_IDLE;
        end else begin
          nl = next_line(s.line, form_len(s.vfu_loaded, s.vfu_len));
          n.step = 1'b1;
          n.line = nl;
          n.timer = 16'(STEP_CYC - 1);
          n.move_left = s.move_left - 8'h01;
          // A seek ends after one full form if the channel is absent
          unique case (s.kind)
            PVF_MV_ONE: n.st = PVF_IDLE;
            PVF_MV_TOP: if (nl == 8'h00) n.st = PVF_IDLE;
            PVF_MV_TAB: if (s.vfu[nl] == s.target || s.move_left <= 8'h01) n.st = PVF_IDLE;
            PVF_MV_SLEW: n.st = PVF_MOVE;
          endcase
        end
      end
    endcase

    // Ready only when idle and on-line; never in the accepting cycle
    n.ready = (n.st == PVF_IDLE) && n.online && !accept;
    n.error = fault_now;
    n.irq = int_enable & (n.ready | n.error);
  end

  // State register; interrupt identity comes from parameters
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.vfu <= {`PVF_FORM_MAX{`PVF_CH_NONE}};
      s.irq_level <= IRQ_LEVEL;
      s.irq_vector <= IRQ_VECTOR;
    end else begin
      s <= n;
    end
  end

  assign ready = s.ready;
  assign error = s.error;
  assign irq_req = s.irq;
  assign irq_level = s.irq_level;
  assign irq_vector = s.irq_vector;
  assign print_valid = s.print_valid;
  assign print_data = s.print_data;
  assign paper_step = s.step;
  assign step_eighth = s.eighth;
  assign fault_lit = s.fault;
  assign online_lit = s.online;
  assign lpi8_lit = s.lpi8_panel;
  assign vfu_loaded = s.vfu_loaded;
  assign form_line = s.line;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_irq_needs_enable: assert property (!int_enable |=> !irq_req)
    else $error("interrupt without enable");
  a_irq_on_status: assert property ((int_enable ##1 (ready || error)) |-> irq_req)
    else $error("ready or error without interrupt");
  a_irq_ident: assert property (irq_level == IRQ_LEVEL && irq_vector == IRQ_VECTOR)
    else $error("interrupt level or vector wrong");
  a_ready_drops: assert property (char_wr && ready |=> !ready)
    else $error("ready held after a write");
  a_ready_idle: assert property (ready |-> online_lit && !print_valid)
    else $error("ready while busy or off-line");
  a_error_follows: assert property (error == fault_lit)
    else $error("error bit differs from fault light");
  a_fault_online: assert property (fault_lit |-> !online_lit)
    else $error("on-line with fault lit");
  a_load_routes: assert property (s.loading && ready && char_wr |=> !print_valid)
    else $error("load character reached print line");
  a_stop_ends: assert property (s.loading && ready && char_wr && char_data == `PVF_CODE_STOP |=> !s.loading)
    else $error("stop code did not end loading");
  a_len_bound: assert property (s.vfu_len <= `PVF_FORM_MAX_W)
    else $error("format buffer overrun");
  a_tof_line1: assert property (s.vfu_len != 8'h00 |-> s.vfu[0] == `PVF_CH_TOF)
    else $error("line one lacks top-of-form");
  a_lpi_offline: assert property (online_lit |=> $stable(lpi8_lit))
    else $error("spacing toggled on-line");
  a_step_gap: assert property (paper_step |=> !paper_step [*2])
    else $error("paper steps too close");

  c_vfu_load: cover property (s.loading ##[1:400] s.vfu_loaded);
  c_tab_seek: cover property (s.st == PVF_MOVE && s.kind == PVF_MV_TAB ##1 paper_step);
  c_slew: cover property (s.kind == PVF_MV_SLEW && paper_step);
endmodule

// ### pkg/pvf_params.svh
// Constants for the vertical format, interrupt and panel controller
`ifndef PVF_PARAMS_SVH
`define PVF_PARAMS_SVH

// In-band character codes
`define PVF_CODE_LF 8'h0A
`define PVF_CODE_FF 8'h0C
`define PVF_CODE_SHIFT8 8'h06
`define PVF_CODE_START 8'h1E
`define PVF_CODE_STOP 8'h1F
`define PVF_TAB_FIRST 8'h10
`define PVF_TAB_LAST 8'h1D

// Format buffer geometry and channel codes
`define PVF_FORM_MAX 132
`define PVF_FORM_MAX_W 8'h84
`define PVF_FORM_DEFAULT 66
`define PVF_CH_TOF 4'h0
`define PVF_CH_NONE 4'hF

// Interrupt defaults: level 4, vector 200 octal
`define PVF_IRQ_LEVEL 3'h4
`define PVF_IRQ_VECTOR 9'h080

// Timing: one paper step interval
`define PVF_CLK_NS 10
`define PVF_STEP_TIME_NS 5000
`define PVF_STEP_CYC ((`PVF_STEP_TIME_NS + `PVF_CLK_NS - 1) / `PVF_CLK_NS)

// Synchronised pin vector layout
`define PVF_PIN_W 13
`define PVF_PIN_PAPER_OUT 0
`define PVF_PIN_FAULT_BTN 7
`define PVF_PIN_ONLINE_BTN 8
`define PVF_PIN_LPI_BTN 9
`define PVF_PIN_TOF_BTN 10
`define PVF_PIN_ADV_BTN 11
`define PVF_PIN_TAKE 12

`endif

// ### pkg/pvf_pkg.sv
// Types for the vertical format, interrupt and panel controller
`include "pvf_params.svh"
package pvf_pkg;

  typedef enum logic [1:0] {PVF_IDLE, PVF_PRINT, PVF_MOVE} pvf_state_t;
  typedef enum logic [1:0] {PVF_MV_ONE, PVF_MV_TOP, PVF_MV_TAB, PVF_MV_SLEW} pvf_move_t;

  typedef struct packed {
    pvf_state_t st;
    pvf_move_t kind;
    logic online;
    logic fault;
    logic reload_hold;
    logic lpi8_panel;
    logic prog_8lpi;
    logic loading;
    logic vfu_loaded;
    logic [7:0] vfu_len;
    logic [`PVF_FORM_MAX-1:0][3:0] vfu;
    logic [7:0] line;
    logic tab_pend;
    logic [3:0] tab_ch;
    logic [3:0] target;
    logic [7:0] move_left;
    logic [15:0] timer;
    logic [7:0] print_data;
    logic print_valid;
    logic ready;
    logic error;
    logic irq;
    logic [2:0] irq_level;
    logic [8:0] irq_vector;
    logic step;
    logic eighth;
    logic [`PVF_PIN_W-1:0] prev;
  } pvf_st_t;

endpackage

// ### rtl/pvf_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pvf_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pvf_sync_st_t;

  pvf_sync_st_t s;
  pvf_sync_st_t n;

  // Output moves only once stages two and three agree
  always_comb begin
    n = s;
    n.s1 = d;
    n.s2 = s.s1;
    n.s3 = s.s2;
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        n.q[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign q = s.q;
endmodule

// ### bench/pvf_host.sv
// Host processor model writing characters into the controller
`timescale 1ns/1ps
module pvf_host (
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] code,
  input wire logic ready,
  output logic char_wr,
  output logic [7:0] char_data,
  output logic busy
);
  logic [7:0] held;
  // Write only on ready; data line shows junk outside the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      char_wr <= 1'b0;
      busy <= 1'b0;
      char_data <= 8'h00;
      held <= 8'h00;
    end else if (go) begin
      held <= code;
      busy <= 1'b1;
    end else if (char_wr) begin
      char_wr <= 1'b0;
      busy <= 1'b0;
      char_data <= ~held;
    end else if (busy && ready) begin
      char_wr <= 1'b1;
      char_data <= held;
    end
  end
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the format, interrupt and panel controller
`timescale 1ns/1ps
`include "pvf_params.svh"
module tb_top;
  import pvf_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic [7:0] code = 8'h00;
  logic int_enable = 1'b0;
  logic [6:0] fault_pins = 7'h00;
  logic [4:0] btn = 5'h00;
  logic mech_take = 1'b0;
  logic char_wr, busy, ready, error, irq_req, print_valid, paper_step;
  logic step_eighth, fault_lit, online_lit, lpi8_lit, vfu_loaded;
  logic [7:0] char_data, print_data, form_line;
  logic [2:0] irq_level;
  logic [8:0] irq_vector;
  int fail_count = 0;
  int compares = 0;
  int i;
  int n;
  always #5 mclk = ~mclk;
  pvf_host host (.mclk(mclk), .rst(rst), .go(go), .code(code), .ready(ready),
    .char_wr(char_wr), .char_data(char_data), .busy(busy));
  // Short step interval keeps paper moves brief
  pvf_ctrl #(.STEP_CYC(4)) dut (.mclk(mclk), .rst(rst), .char_wr(char_wr),
    .char_data(char_data), .int_enable(int_enable), .fault_pins(fault_pins),
    .fault_button(btn[0]), .online_button(btn[1]), .lpi_button(btn[2]),
    .tof_button(btn[3]), .advance_button(btn[4]), .mech_take(mech_take),
    .ready(ready), .error(error), .irq_req(irq_req), .irq_level(irq_level),
    .irq_vector(irq_vector), .print_valid(print_valid), .print_data(print_data),
    .paper_step(paper_step), .step_eighth(step_eighth), .fault_lit(fault_lit),
    .online_lit(online_lit), .lpi8_lit(lpi8_lit), .vfu_loaded(vfu_loaded),
    .form_line(form_line));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Pushbutton held long enough to pass the synchroniser
  task automatic press(input int k);
    btn[k] <= 1'b1;
    cyc(10);
    btn[k] <= 1'b0;
    cyc(10);
  endtask
  task automatic wait_ready();
    for (i = 0; i < 400 && ready !== 1'b1; i++) @(posedge mclk);
    chk(ready, 1'b1);
  endtask
  // Hand one code to the host, then wait until it has been written
  task automatic send(input logic [7:0] c);
    wait_ready();
    code <= c;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(1);
    for (i = 0; i < 50 && busy === 1'b1; i++) @(posedge mclk);
    chk(busy, 1'b0);
    cyc(1);
  endtask
  // Mechanism takes the offered character
  task automatic take();
    for (i = 0; i < 50 && print_valid !== 1'b1; i++) @(posedge mclk);
    chk(print_valid, 1'b1);
    mech_take <= 1'b1;
    for (i = 0; i < 50 && print_valid === 1'b1; i++) @(posedge mclk);
    chk(print_valid, 1'b0);
    mech_take <= 1'b0;
    wait_ready();
    cyc(2);
  endtask
  task automatic t_reset();
    chk(irq_level, 3'h4);
    chk(irq_vector, 9'h080);
    chk(ready, 1'b0);
  endtask
  // Off-line panel: slew, top of form, spacing toggle
  task automatic t_panel();
    n = 0;
    btn[4] <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk);
      if (paper_step === 1'b1) n++;
    end
    btn[4] <= 1'b0;
    for (int k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (paper_step === 1'b1) n++;
    end
    chk(n >= 5, 1'b1);
    chk(form_line, n[7:0]);
    press(3);
    // Top of form walks the rest of the default form, one step interval a line
    cyc(40 + 4 * (`PVF_FORM_DEFAULT - n));
    chk(form_line, 8'h00);
    press(2);
    chk(lpi8_lit, 1'b1);
    press(1);
    chk(online_lit, 1'b1);
    chk(ready, 1'b1);
    press(2);
    chk(lpi8_lit, 1'b1);
  endtask
  // Printable character, ready handshake and interrupt request
  task automatic t_print();
    int_enable <= 1'b1;
    send(8'h41);
    chk(ready, 1'b0);
    chk(irq_req, 1'b0);
    chk({print_valid, print_data}, 9'h141);
    take();
    chk(ready, 1'b1);
    chk(irq_req, 1'b1);
  endtask
  // Format load, then tab seeks to loaded channels
  task automatic t_vfu();
    send(8'h1E);
    send(8'h13);
    chk(print_valid, 1'b0);
    send(8'h20);
    send(8'h12);
    send(8'h20);
    send(8'h1F);
    wait_ready();
    chk(vfu_loaded, 1'b1);
    send(8'h10);
    send(8'h0A);
    chk(print_valid, 1'b1);
    take();
    chk(form_line, 8'h00);
    send(8'h12);
    send(8'h0A);
    take();
    chk(form_line, 8'h02);
  endtask
  // Fault light, forced off-line, reload latch
  task automatic t_fault();
    fault_pins <= 7'h02;
    cyc(10);
    chk({fault_lit, error, online_lit}, 3'h6);
    chk(irq_req, 1'b1);
    int_enable <= 1'b0;
    cyc(2);
    chk(irq_req, 1'b0);
    press(1);
    chk(online_lit, 1'b0);
    fault_pins <= 7'h00;
    cyc(10);
    chk(fault_lit, 1'b0);
    fault_pins <= 7'h01;
    cyc(10);
    fault_pins <= 7'h00;
    cyc(10);
    chk(fault_lit, 1'b1);
    press(0);
    chk(fault_lit, 1'b0);
  endtask
  // Panel at 6 lpi on-line: program PVF_CODE_SHIFT8 for one feed, then form feed
  task automatic t_spacing();
    press(2);
    chk(lpi8_lit, 1'b0);
    press(1);
    chk(online_lit, 1'b1);
    send(8'h06);
    send(8'h0A);
    take();
    chk(step_eighth, 1'b1);
    chk(form_line, 8'h03);
    send(8'h0C);
    take();
    chk(step_eighth, 1'b0);
    chk(form_line, 8'h00);
  endtask
  // Main sequence
  initial begin
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    t_reset();
    t_panel();
    t_print();
    t_vfu();
    t_fault();
    t_spacing();
    conclude();
  end
  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
endmodule
